// file: pdrc_top.sv
// Contract
// - sleep with mode 010 and sleep enable set enters power-down
// - power-down stops fast oscillator, external clock, monitor, brown-out unless kept on
// - power-down wakes only on resets, receiver start, level irqs, pin change
// - power-down gates every generated clock except the enabled slow oscillator
// - power-down wake waits the fuse-selected start-up period
// - in noise reduction and power-down, irq lines wake only as level
// - monitor, thermal and brown-out wake power-down only when kept on
// - reset loads I/O initial values; release starts fetch at reset vector
// - I/O ports reset at once by any source, without a clock
// - internal reset stretched by fuse-selected delay counter after all release
// - five reset sources: power-on, pin, watchdog, brown-out, temperature
// - pin low for 2 us gives reset; partner holds it that long
// - watchdog expiry resets only while watchdog enabled
// - brown-out resets only while detection enabled
// - over-temperature resets only while shutdown enabled
// - power-on rise starts delay; supply fall re-asserts reset at once
// - pin high starts delay counter; release after time-out
// - interrupt wake halts four cycles beyond start-up, then resumes
// - watchdog gives one-cycle reset pulse; delay starts at its end
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module pdrc_top
  import pdrc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset sources
  input wire logic por_low,
  input wire logic reset_pin_n,
  input wire logic wdt_expire,
  input wire logic bod_below,
  input wire logic temp_over,
  // wake sources and cpu
  input wire logic [7:0] wake_irq,
  input wire logic sleep_instr,
  // fuses
  input wire logic [1:0] startup_time_fuse,
  input wire logic [1:0] clock_source_fuse,
  // reset outputs
  output logic core_reset,
  output logic io_port_reset,
  output logic vector_fetch,
  // cpu and clock control
  output logic cpu_halt,
  output logic resume_pulse,
  output logic fast_rc_enable,
  output logic ext_clock_enable,
  output logic voltage_monitor_enable,
  output logic bod_active,
  output logic gen_clock_enable,
  output logic slow_clock_enable
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0] sleep_ctrl_reg;
  logic [7:0] vm_ctrl_reg;
  logic [3:0] src_meta_reg;
  logic [3:0] src_sync_reg;
  logic [7:0] wake_meta_reg;
  logic [7:0] wake_sync_reg;
  logic [7:0] pin_cnt_reg;
  logic wdt_pulse_reg;
  logic [11:0] tout_cnt_reg;
  logic core_reset_reg;
  logic vector_fetch_reg;
  logic [11:0] wake_cnt_reg;
  logic [1:0] halt_cnt_reg;
  logic resume_reg;
  pdrc_state_e state_reg;
  pdrc_state_e state_next;
  logic [11:0] period;
  logic pin_rst;
  logic por_s;
  logic bod_s;
  logic temp_s;
  logic rst_req;
  logic wake_pd;
  logic wake_light;
  logic stay_on;
  logic wr_go;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;

  assign stay_on = vm_ctrl_reg[STAY_ON_BIT];

  // ------------------------------------------------------------
  // synchronisers for pins and analog monitors
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_meta_reg <= 4'h2;
      src_sync_reg <= 4'h2;
      wake_meta_reg <= 8'h00;
      wake_sync_reg <= 8'h00;
    end
    else
    begin
      src_meta_reg <= {temp_over, bod_below, reset_pin_n, por_low};
      src_sync_reg <= src_meta_reg;
      wake_meta_reg <= wake_irq;
      wake_sync_reg <= wake_meta_reg;
    end
  end
  assign por_s = src_sync_reg[0];
  assign bod_s = src_sync_reg[2];
  assign temp_s = src_sync_reg[3];

  // ------------------------------------------------------------
  // reset sources and delay counter
  // ------------------------------------------------------------
  // pin low filter
  // pulses shorter than the minimum width may still reset the ports only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_cnt_reg <= 8'h00;
    else if (src_sync_reg[1])
      pin_cnt_reg <= 8'h00;
    else if (pin_cnt_reg != 8'(RST_MIN_CYC))
      pin_cnt_reg <= pin_cnt_reg + 8'h01;
  end
  assign pin_rst = (pin_cnt_reg == 8'(RST_MIN_CYC));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdt_pulse_reg <= 1'b0;
    else
      wdt_pulse_reg <= wdt_expire && vm_ctrl_reg[WDT_EN_BIT] && !wdt_pulse_reg;
  end

  assign rst_req = por_s || pin_rst || wdt_pulse_reg || (bod_s && bod_active)
                   || (temp_s && vm_ctrl_reg[TS_EN_BIT]);

  always_comb
  begin
    unique case (startup_time_fuse)
      2'h0: period = 12'(TOUT_CYC_0);
      2'h1: period = 12'(TOUT_CYC_1);
      2'h2: period = 12'(TOUT_CYC_2);
      2'h3: period = 12'(TOUT_CYC_3);
    endcase
    if (clock_source_fuse[0])
      period = {period[10:0], 1'b0};
  end

  // supply fall asserts reset on the third edge, through the two-stage synchroniser, no delay
  // counting starts once every reset source is idle again
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tout_cnt_reg <= 12'h000;
      core_reset_reg <= 1'b1;
      vector_fetch_reg <= 1'b0;
    end
    else
    begin
      if (rst_req)
        tout_cnt_reg <= period;
      else if (tout_cnt_reg != 12'h000)
        tout_cnt_reg <= tout_cnt_reg - 12'h001;
      core_reset_reg <= rst_req || (tout_cnt_reg != 12'h000);
      // fetch from reset vector at release
      vector_fetch_reg <= core_reset_reg && !rst_req && (tout_cnt_reg == 12'h000);
    end
  end
  assign core_reset = core_reset_reg;
  assign vector_fetch = vector_fetch_reg;

  // port reset from the raw sources, which need no clock, and from the stretched core reset
  // a disabled watchdog is no reset source, so its expiry must not touch the ports
  assign io_port_reset = por_low || !reset_pin_n || (wdt_expire && vm_ctrl_reg[WDT_EN_BIT]) || core_reset_reg
                         || (bod_below && bod_active) || (temp_over && vm_ctrl_reg[TS_EN_BIT]);

  // ------------------------------------------------------------
  // sleep state machine
  // ------------------------------------------------------------
  // power-down wake set
  // irq lines only when configured as level
  // monitor, thermal, brown-out only when kept on
  // a level must survive the synchroniser to be seen
  assign wake_pd = wake_sync_reg[W_LF] || wake_sync_reg[W_PCH]
                   || (wake_sync_reg[W_EXT_IRQ_ZERO] && vm_ctrl_reg[LEVEL0_BIT])
                   || (wake_sync_reg[W_EXT_IRQ_ONE] && vm_ctrl_reg[LEVEL1_BIT])
                   || (stay_on && (wake_sync_reg[W_VM] || wake_sync_reg[W_TS] || wake_sync_reg[W_BOD]));
  assign wake_light = (sleep_ctrl_reg[3:1] == SM_NOISE) ? (wake_pd || wake_sync_reg[W_OTHER]
                      || wake_sync_reg[W_VM] || wake_sync_reg[W_TS] || wake_sync_reg[W_BOD]) : (|wake_sync_reg);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN:
        if (sleep_instr && sleep_ctrl_reg[SE_BIT])
          state_next = (sleep_ctrl_reg[3:1] == SM_PDOWN) ? ST_PDOWN : ST_LIGHT;
      ST_LIGHT:
        if (wake_light)
          state_next = ST_HALT;
      ST_PDOWN:
        if (wake_pd)
          state_next = ST_WAKE;
      ST_WAKE:
        if (wake_cnt_reg == 12'h000)
          state_next = ST_HALT;
      ST_HALT:
        if (halt_cnt_reg == 2'h0)
          state_next = ST_RUN;
    endcase
  end

  // reset sources override sleep: the core restarts from the vector instead
  always_ff @(posedge aclk)
  begin
    if (!aresetn || rst_req)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wake_cnt_reg <= 12'h000;
      halt_cnt_reg <= 2'h0;
      resume_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == ST_PDOWN)
        wake_cnt_reg <= period;
      else if (wake_cnt_reg != 12'h000)
        wake_cnt_reg <= wake_cnt_reg - 12'h001;
      if (state_reg != ST_HALT)
        halt_cnt_reg <= 2'(HALT_CYC - 1);
      else if (halt_cnt_reg != 2'h0)
        halt_cnt_reg <= halt_cnt_reg - 2'h1;
      resume_reg <= (state_reg == ST_HALT) && (halt_cnt_reg == 2'h0) && !rst_req;
    end
  end
  assign resume_pulse = resume_reg;
  assign cpu_halt = (state_reg != ST_RUN);

  // fast and external oscillators stop in power-down, monitors too unless kept on
  // only the slow clock survives power-down
  assign fast_rc_enable = (state_reg != ST_PDOWN);
  assign ext_clock_enable = (state_reg != ST_PDOWN);
  assign gen_clock_enable = (state_reg != ST_PDOWN);
  assign voltage_monitor_enable = (state_reg != ST_PDOWN) || stay_on;
  assign bod_active = vm_ctrl_reg[BOD_EN_BIT] && ((state_reg != ST_PDOWN) || stay_on);
  assign slow_clock_enable = vm_ctrl_reg[SLOW_OSC_BIT];

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  // address and data are taken together; a waiting master loses nothing
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_go = s_axi_awready;
  assign wr_hit = (s_axi_awaddr == ADDR_SLEEP_CTRL) || (s_axi_awaddr == ADDR_VM_CTRL);
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit = (s_axi_araddr == ADDR_SLEEP_CTRL) || (s_axi_araddr == ADDR_VM_CTRL)
                  || (s_axi_araddr == ADDR_STATUS);

  // control registers, low byte lane only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_ctrl_reg <= SLEEP_CTRL_RST;
      vm_ctrl_reg <= VM_CTRL_RST;
    end
    else if (wr_go && s_axi_wstrb[0])
    begin
      if (s_axi_awaddr == ADDR_SLEEP_CTRL)
        sleep_ctrl_reg <= {4'h0, s_axi_wdata[3:0]};
      if (s_axi_awaddr == ADDR_VM_CTRL)
        vm_ctrl_reg <= {1'b0, s_axi_wdata[6:0]};
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // status view of the block's own state
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == ADDR_SLEEP_CTRL)
      rd_val = {24'h00_0000, sleep_ctrl_reg};
    else if (s_axi_araddr == ADDR_VM_CTRL)
      rd_val = {24'h00_0000, vm_ctrl_reg};
    else if (s_axi_araddr == ADDR_STATUS)
      rd_val = {15'h0000, core_reset_reg, wake_sync_reg, 5'h00, 3'(state_reg)};
  end

  // read response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pdown_entry: assert property (
    (state_reg == ST_RUN) && sleep_instr && sleep_ctrl_reg[SE_BIT] && (sleep_ctrl_reg[3:1] == SM_PDOWN) && !rst_req
    |=> (state_reg == ST_PDOWN)) else $error("power-down not entered");
  a_pd_clocks_off: assert property (
    (state_reg == ST_PDOWN) |-> !gen_clock_enable && !fast_rc_enable && !ext_clock_enable)
    else $error("clock running in power-down");
  a_bod_gated: assert property (
    (state_reg == ST_PDOWN) && !stay_on |-> !bod_active && !voltage_monitor_enable)
    else $error("monitor running in power-down");
  a_pd_wake: assert property (
    (state_reg == ST_PDOWN) && wake_pd && !rst_req |=> (state_reg == ST_WAKE) || rst_req)
    else $error("power-down wake missed");
  a_halt_four: assert property (
    disable iff (!aresetn || rst_req)
    $rose(state_reg == ST_HALT) |-> (state_reg == ST_HALT) [*4] ##1 resume_pulse)
    else $error("halt not four cycles");
  a_wdt_pulse: assert property (
    wdt_expire && vm_ctrl_reg[WDT_EN_BIT] && !wdt_pulse_reg |=> wdt_pulse_reg ##1 (!wdt_pulse_reg && core_reset))
    else $error("watchdog pulse wrong");
  a_reset_immed: assert property (
    rst_req |=> core_reset) else $error("reset not asserted at once");
  a_reset_hold: assert property (
    $fell(rst_req) |-> core_reset [*8]) else $error("reset released before time-out");
  a_port_reset: assert property (
    por_low || !reset_pin_n |-> io_port_reset) else $error("ports not reset");

endmodule
`default_nettype wire

// file: pdrc_pkg.sv
package pdrc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VM_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] SLEEP_CTRL_RST = 8'h00;
  localparam logic [7:0] VM_CTRL_RST = 8'h00;

  // sleep control fields
  localparam int SE_BIT = 0;
  localparam int SM_LSB = 1;
  localparam logic [2:0] SM_IDLE = 3'h0;
  localparam logic [2:0] SM_NOISE = 3'h1;
  localparam logic [2:0] SM_PDOWN = 3'h2;

  // voltage monitor control fields
  localparam int STAY_ON_BIT = 0;
  localparam int BOD_EN_BIT = 1;
  localparam int TS_EN_BIT = 2;
  localparam int WDT_EN_BIT = 3;
  localparam int SLOW_OSC_BIT = 4;
  localparam int LEVEL0_BIT = 5;
  localparam int LEVEL1_BIT = 6;

  // wake source vector positions
  localparam int W_LF = 0;
  localparam int W_EXT_IRQ_ZERO = 1;
  localparam int W_EXT_IRQ_ONE = 2;
  localparam int W_PCH = 3;
  localparam int W_VM = 4;
  localparam int W_TS = 5;
  localparam int W_BOD = 6;
  localparam int W_OTHER = 7;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_MIN_US = 2;
  localparam int RST_MIN_CYC = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALT_CYC = 4;
  localparam int TOUT_NS_0 = 160;
  localparam int TOUT_NS_1 = 640;
  localparam int TOUT_NS_2 = 2560;
  localparam int TOUT_NS_3 = 10240;
  localparam int TOUT_CYC_0 = TOUT_NS_0 / CLK_PERIOD_NS;
  localparam int TOUT_CYC_1 = TOUT_NS_1 / CLK_PERIOD_NS;
  localparam int TOUT_CYC_2 = TOUT_NS_2 / CLK_PERIOD_NS;
  localparam int TOUT_CYC_3 = TOUT_NS_3 / CLK_PERIOD_NS;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_RUN, ST_LIGHT, ST_PDOWN, ST_WAKE, ST_HALT} pdrc_state_e;

endpackage

// file: pdrc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pdrc_partner
(
  // clock
  input wire logic aclk,
  // reset sources
  output logic por_low,
  output logic reset_pin_n,
  output logic wdt_expire,
  output logic bod_below,
  output logic temp_over,
  // wake requests
  output logic [7:0] wake_irq
);
  // ------------------------------------------------------------
  // source drivers
  // ------------------------------------------------------------
  // all quiet at time zero; the pin rests high as with its pull-up
  initial
  begin
    por_low = 1'b0;
    reset_pin_n = 1'b1;
    wdt_expire = 1'b0;
    bod_below = 1'b0;
    temp_over = 1'b0;
    wake_irq = 8'h00;
  end

  // one source to active (v=1) or idle (v=0); changed right after an edge
  task automatic set(input int s, input logic v);
    case (s)
      0: por_low <= v;
      1: reset_pin_n <= !v;
      2: wdt_expire <= v;
      3: bod_below <= v;
      default: temp_over <= v;
    endcase
  endtask

  task automatic src(input int s, input int n);
    set(s, 1'b1);
    repeat (n) @(posedge aclk);
    set(s, 1'b0);
  endtask

  task automatic wake(input int i, input int n);
    wake_irq[i] <= 1'b1;
    repeat (n) @(posedge aclk);
    wake_irq[i] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: powerdown_and_reset_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module powerdown_and_reset_control_tb
  import pdrc_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_instr;
  logic [7:0] s_axi_awaddr, s_axi_araddr, wake_irq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, stf, csf;
  logic por_low, reset_pin_n, wdt_expire, bod_below, temp_over, core_reset, io_port_reset, vector_fetch;
  logic cpu_halt, resume_pulse, fast_rc_enable, ext_clock_enable, voltage_monitor_enable, bod_active;
  logic gen_clock_enable, slow_clock_enable;
  logic [33:0] exp_q[$];
  int errors = 0;
  int comparisons = 0;
  int vf_cnt = 0;
  int period;

  pdrc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .por_low, .reset_pin_n,
    .wdt_expire, .bod_below, .temp_over, .wake_irq, .sleep_instr, .startup_time_fuse(stf),
    .clock_source_fuse(csf), .core_reset, .io_port_reset, .vector_fetch, .cpu_halt, .resume_pulse,
    .fast_rc_enable, .ext_clock_enable, .voltage_monitor_enable, .bod_active, .gen_clock_enable,
    .slow_clock_enable);

  pdrc_partner p (.aclk, .por_low, .reset_pin_n, .wdt_expire, .bod_below, .temp_over, .wake_irq);

  // ------------------------------------------------------------
  // clock, checking helpers
  // ------------------------------------------------------------
  // 100 MHz
  always #5 aclk = ~aclk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic win(input int n, input int lo, input int hi);
    chk(34'(n >= lo && n <= hi), 34'h1, "cycle count");
  endtask

  // bus answers are matched to the oldest note; fetch pulses are counted
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      chk({32'h0, s_axi_bresp}, exp_q.pop_front(), "write answer");
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front(), "read answer");
    if (vector_fetch === 1'b1)
      vf_cnt++;
  end

  // ------------------------------------------------------------
  // bus master
  // ------------------------------------------------------------
  // each task ends one edge after releasing its ready, so no signal is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({32'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // ------------------------------------------------------------
  // reset and sleep helpers
  // ------------------------------------------------------------
  // capped wait, so a stuck reset shows as a bad count, not a hang
  task automatic till_core(input logic lvl, output int n);
    n = 0;
    while (core_reset !== lvl && n < 5000)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  // release time, then exactly one fetch from the vector
  task automatic rel(input int lo, input int hi);
    int n;
    int v;
    v = vf_cnt;
    till_core(1'b0, n);
    win(n, lo, hi);
    repeat (3) @(posedge aclk);
    chk(34'(vf_cnt - v), 34'h1, "vector fetch");
  endtask

  // capped wait for the resume pulse after a wake
  task automatic till_resume(output int n);
    n = 0;
    while (resume_pulse !== 1'b1 && n < 5000)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic slp(input logic [7:0] vm, input logic [7:0] sc);
    wr(ADDR_VM_CTRL, {24'h0, vm}, RESP_OKAY);
    wr(ADDR_SLEEP_CTRL, {24'h0, sc}, RESP_OKAY);
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic conclude();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog at 60k cycles, well past the longest expected run of some 30k cycles
  initial
  begin
    #600000;
    errors++;
    conclude();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    int n;
    int hold[5] = '{10, 250, 1, 10, 10};
    logic [7:0] en[5] = '{8'h00, 8'h00, 8'h08, 8'h02, 8'h04};
    logic [7:0] vmp[6] = '{8'h12, 8'h32, 8'h52, 8'h12, 8'h13, 8'h01};
    int neg[6] = '{7, 1, 2, 4, 5, 6};
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_instr} = 6'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    void'($urandom(26));
    stf = 2'($urandom);
    csf = 2'($urandom);
    period = (stf == 0) ? TOUT_CYC_0 : (stf == 1) ? TOUT_CYC_1 : (stf == 2) ? TOUT_CYC_2 : TOUT_CYC_3;
    period = period * (csf[0] ? 2 : 1);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    till_core(1'b0, n);
    rd(ADDR_SLEEP_CTRL, {RESP_OKAY, 24'h0, SLEEP_CTRL_RST});
    rd(ADDR_VM_CTRL, {RESP_OKAY, 24'h0, VM_CTRL_RST});
    rd(ADDR_STATUS, {RESP_OKAY, 32'h0});
    rd(8'h0C, {RESP_SLVERR, 32'h0});
    wr(8'h0C, 32'h1, RESP_SLVERR);
    $display("test registers done");
    // each source asserts and stretches reset; watchdog, brown-out and temperature are first refused while disabled
    for (int s = 0; s < 5; s++)
    begin
      if (en[s] != 8'h00)
      begin
        wr(ADDR_VM_CTRL, 32'h0, RESP_OKAY);
        p.src(s, hold[s]);
        repeat (6) @(posedge aclk);
        chk(core_reset, 1'b0, "disabled source");
      end
      wr(ADDR_VM_CTRL, {24'h0, en[s]}, RESP_OKAY);
      p.src(s, hold[s]);
      till_core(1'b1, n);
      win(n, 0, 4);
      rel(period, period + 8);
    end
    $display("test reset sources done");
    fork
      p.src(1, 50);
    join_none
    repeat (2) @(posedge aclk);
    chk(io_port_reset, 1'b1, "port reset");
    repeat (60) @(posedge aclk);
    chk(core_reset, 1'b0, "short pin pulse");
    fork
      p.src(0, 10);
    join_none
    till_core(1'b1, n);
    win(n, 1, 5);
    repeat (10 + period / 2) @(posedge aclk);
    p.src(0, 4);
    rel(period, period + 8);
    $display("test restart done");
    slp(8'h00, 8'h04);
    chk({fast_rc_enable, cpu_halt}, 2'b10, "sleep disabled");
    slp(8'h02, 8'h05);
    chk({fast_rc_enable, ext_clock_enable, gen_clock_enable, voltage_monitor_enable, bod_active}, 5'h0,
      "power-down clocks");
    // sources that must not wake power-down here
    for (int k = 0; k < 6; k++)
    begin
      p.wake(neg[k], 10);
      repeat (8) @(posedge aclk);
      rd(ADDR_STATUS, {RESP_OKAY, 32'h2});
    end
    // each legal wake source except brown-out, with the start-up wait and four-cycle halt
    for (int k = 0; k < 6; k++)
    begin
      slp(vmp[k], 8'h05);
      chk({slow_clock_enable, voltage_monitor_enable, bod_active, cpu_halt},
        {vmp[k][4], vmp[k][0], vmp[k][0] & vmp[k][1], 1'b1}, "power-down enables");
      fork
        p.wake(k, 20);
      join_none
      till_resume(n);
      win(n, period + 4, period + 12);
      @(posedge aclk);
      chk({fast_rc_enable, cpu_halt}, 2'b10, "running again");
    end
    $display("test power-down done");
    slp(8'h00, 8'h03);
    p.wake(1, 10);
    repeat (8) @(posedge aclk);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h1});
    // an internal irq still wakes noise reduction, with no start-up wait
    fork
      p.wake(7, 5);
    join_none
    till_resume(n);
    win(n, 4, 12);
    $display("test noise reduction done");
    // idle wakes on any request, even an edge-configured irq line
    slp(8'h00, 8'h01);
    chk(cpu_halt, 1'b1, "idle entered");
    fork
      p.wake(1, 5);
    join_none
    till_resume(n);
    win(n, 4, 12);
    $display("test idle done");
    conclude();
  end
endmodule
`default_nettype wire
